/* hdl/dhp_pkg.sv */
// Purpose: constants shared by the host bus port of the dual serial controller
// Assumes: one 200 MHz clock, synchronous active-low reset
// Notes:   register map, field positions, reset values and fifo figures
package dhp_pkg;
    localparam int DATA_W     = 8;
    localparam int ADDR_W     = 4;
    localparam int FIFO_DEPTH = 8;
    localparam int PTR_W      = 3;
    localparam int CNT_W      = 4;
    localparam int IP_W       = 7;
    localparam int COS_W      = 4;
    // register addresses; bit 3 picks channel for the low four
    localparam logic [3:0] A_MR       = 4'h0;
    localparam logic [3:0] A_SR       = 4'h1;
    localparam logic [3:0] A_CR       = 4'h2;
    localparam logic [3:0] A_DAT      = 4'h3;
    localparam logic [3:0] A_IPCR     = 4'h4;
    localparam logic [3:0] A_ISR      = 4'h5;
    localparam logic [3:0] A_CT_START = 4'h6;
    localparam logic [3:0] A_CT_STOP  = 4'h7;
    localparam logic [3:0] A_OUT_PORT_CONFIG_REG     = 4'hD;
    localparam logic [3:0] A_OP_SET   = 4'hE;
    localparam logic [3:0] A_OP_CLR   = 4'hF;
    // mode register pointer values
    localparam logic [1:0] MRP_0 = 2'h0;
    localparam logic [1:0] MRP_1 = 2'h1;
    localparam logic [1:0] MRP_2 = 2'h2;
    // command register fields
    localparam int CR_RX_EN  = 0;
    localparam int CR_RX_DIS = 1;
    localparam int CR_TX_EN  = 2;
    localparam int CR_TX_DIS = 3;
    localparam logic [2:0] CMD_PTR_MR1 = 3'h1;
    localparam logic [2:0] CMD_RST_RX  = 3'h2;
    localparam logic [2:0] CMD_RST_TX  = 3'h3;
    localparam logic [2:0] CMD_RST_ERR = 3'h4;
    localparam logic [2:0] CMD_PTR_MR0 = 3'h5;
    // channel status bits
    localparam int SR_RXRDY = 0;
    localparam int SR_FULL  = 1;
    localparam int SR_TXRDY = 2;
    localparam int SR_TXEMT = 3;
    localparam int SR_OVR   = 4;
    // interrupt status bits
    localparam int ISR_TXA  = 0;
    localparam int ISR_RXA  = 1;
    localparam int ISR_OVRA = 2;
    localparam int ISR_CT   = 3;
    localparam int ISR_TXB  = 4;
    localparam int ISR_RXB  = 5;
    localparam int ISR_OVRB = 6;
    localparam int ISR_COS  = 7;
    // mode field positions
    localparam int         MR0_RXLVL = 0;
    localparam int         MR0_TXLVL = 2;
    localparam int         MR2_MODE  = 6;
    localparam logic [1:0] MODE_LOOP = 2'h2;
    // fill levels: receiver counts held, transmitter counts free
    localparam logic [15:0] RX_LVL = 16'h8631;
    localparam logic [15:0] TX_LVL = 16'h1648;
    // reset values
    localparam logic [7:0] RST_GP_OUT = 8'hFF;
    localparam logic [7:0] RST_GP_OE  = 8'hFF;
    localparam logic [1:0] RST_SER    = 2'h3;
endpackage : dhp_pkg

/* hdl/dhp_mem.sv */
// Purpose: eight-word character store with registered read data
// Assumes: one write and one read port on the same clock
// Notes:   read data lag the address by one edge
module dhp_mem
    import dhp_pkg::*;
(
    input  logic                           clk,   // system clock
    input  logic                           we,    // write enable
    input  logic [dhp_pkg::PTR_W-1:0]     waddr, // write address
    input  logic [dhp_pkg::DATA_W-1:0]    wdata, // write data
    input  logic [dhp_pkg::PTR_W-1:0]     raddr, // read address
    output logic [dhp_pkg::DATA_W-1:0]    rdata  // registered read data
);
    logic [DATA_W-1:0] mem_r [FIFO_DEPTH];

    // storage and read register
    always_ff @(posedge clk)
    begin
        if (we)
        begin
            mem_r[waddr] <= wdata;
        end
        rdata <= mem_r[raddr];
    end
endmodule : dhp_mem

/* hdl/dhp_port.sv */
// Purpose: host bus port, registers and fifos of the dual serial controller
// Assumes: host strobes are asynchronous and pass two flops first
// Notes:   write lands when the select/write window closes
module dhp_port
    import dhp_pkg::*;
(
    input  logic                        clk,             // 200 MHz clock
    input  logic                        rst_n,           // sync reset
    input  logic                        chip_select_n,   // bus select
    input  logic                        read_strobe_n,   // read strobe
    input  logic                        write_strobe_n,  // write strobe
    input  logic [dhp_pkg::ADDR_W-1:0] reg_addr,        // register address
    input  logic [dhp_pkg::DATA_W-1:0] host_data_in,    // bus level in
    output logic [dhp_pkg::DATA_W-1:0] host_data_out,   // bus drive value
    output logic                        host_data_oe,    // bus drive enable
    output logic                        irq_request_n,   // request level
    output logic                        irq_request_n_oe, // pulls low
    output logic [7:0]                  general_outputs, // port pins
    output logic [7:0]                  general_outputs_oe, // pin drive
    input  logic [dhp_pkg::IP_W-1:0]   input_pins,      // general inputs
    output logic                        serial_out_a,    // line a
    output logic                        serial_out_b,    // line b
    input  logic [1:0]                  tx_line,         // shifter bits
    input  logic [1:0]                  rx_push,         // received char
    input  logic [dhp_pkg::DATA_W-1:0] rx_char_a,       // char a
    input  logic [dhp_pkg::DATA_W-1:0] rx_char_b,       // char b
    input  logic [1:0]                  tx_pop,          // shifter takes
    output logic [1:0]                  tx_valid,        // char ready
    output logic [dhp_pkg::DATA_W-1:0] tx_char_a,       // char a out
    output logic [dhp_pkg::DATA_W-1:0] tx_char_b,       // char b out
    output logic [1:0]                  rx_enabled,      // receiver on
    output logic [1:0]                  tx_enabled,      // transmitter on
    input  logic                        ct_expire,       // counter tick
    output logic                        ct_running       // counter runs
);
    typedef struct packed {
        logic [14:0]       bus_s1;
        logic [14:0]       bus_s2;
        logic [6:0]        ip_s1;
        logic [6:0]        ip_s2;
        logic [3:0]        ip_s3;
        logic              rd_q;
        logic              wv;
        logic [3:0]        wa;
        logic [7:0]        wd;
        logic [7:0]        dout;
        logic              doe;
        logic [1:0][7:0]   mr0;
        logic [1:0][7:0]   mr1;
        logic [1:0][7:0]   mr2;
        logic [1:0][1:0]   mrp;
        logic [1:0]        rx_en;
        logic [1:0]        tx_en;
        logic [1:0]        ovr;
        logic [1:0][2:0]   rx_wp;
        logic [1:0][2:0]   rx_rp;
        logic [1:0][3:0]   rx_cnt;
        logic [1:0][2:0]   tx_wp;
        logic [1:0][2:0]   tx_rp;
        logic [1:0][3:0]   tx_cnt;
        logic [1:0]        popd;
        logic [1:0]        txv;
        logic [1:0][7:0]   sr;
        logic [7:0]        irq_mask_reg;
        logic [7:0]        irq_status_reg;
        logic [7:0]        out_port_reg;
        logic [7:0]        out_port_config_reg;
        logic [3:0]        cos;
        logic              ct_run;
        logic              ct_flag;
        logic              irq_oe;
        logic [7:0]        gp_out;
        logic [7:0]        gp_oe;
        logic [1:0]        ser;
    } dhp_state_t;

    dhp_state_t       s_r;
    dhp_state_t       s_nxt;
    logic [3:0]       mem_we;
    logic [3:0][2:0]  mem_wa;
    logic [3:0][7:0]  mem_wd;
    logic [3:0][2:0]  mem_ra;
    logic [7:0]       mem_q [4];
    logic             cs_l;
    logic             rd_go;
    logic             wr_go;
    logic [1:0]       rx_pop_go;
    logic [1:0]       tx_push_go;
    logic [1:0]       rx_flush;
    logic [1:0]       tx_flush;

    // threshold test for one buffer
    function automatic logic lvl_hit(input logic [3:0] cnt,
                                     input logic [1:0] sel,
                                     input logic       is_tx);
        logic [3:0] lvl;
        lvl = is_tx ? TX_LVL[sel*4 +: 4] : RX_LVL[sel*4 +: 4];
        return is_tx ? ((4'h8 - cnt) >= lvl) : (cnt >= lvl);
    endfunction : lvl_hit

    // status bit routed to an output pin in request mode
    function automatic logic [2:0] op_src(input int k);
        case (k)
            2:       return 3'h2;
            3:       return 3'h3;
            4:       return 3'h1;
            5:       return 3'h5;
            6:       return 3'h0;
            default: return 3'h4;
        endcase
    endfunction : op_src

    ////////////////////////////////////////////////////////////////////
    // four character stores: index 2*channel, +1 for transmit
    for (genvar f = 0; f < 4; f++)
    begin : g_mem
        dhp_mem u_mem (
            .clk   (clk),
            .we    (mem_we[f]),
            .waddr (mem_wa[f]),
            .wdata (mem_wd[f]),
            .raddr (mem_ra[f]),
            .rdata (mem_q[f])
        );
    end

    ////////////////////////////////////////////////////////////////////
    // next state
    always_comb
    begin
        logic       rd_l;
        logic       wr_l;
        logic [3:0] a;
        logic       c;
        logic       wc;
        logic [7:0] d;
        rd_l = 1'b0;
        wr_l = 1'b0;
        a = 4'h0;
        c = 1'b0;
        wc = 1'b0;
        d = 8'h00;
        s_nxt = s_r;
        mem_we = 4'h0;
        rx_pop_go = 2'h0;
        tx_push_go = 2'h0;
        rx_flush = 2'h0;
        tx_flush = 2'h0;
        s_nxt.bus_s1 = {chip_select_n, read_strobe_n, write_strobe_n,
                        reg_addr, host_data_in};
        s_nxt.bus_s2 = s_r.bus_s1;
        s_nxt.ip_s1 = input_pins;
        s_nxt.ip_s2 = s_r.ip_s1;
        s_nxt.ip_s3 = s_r.ip_s2[3:0];
        cs_l = ~s_r.bus_s2[14];
        rd_l = ~s_r.bus_s2[13];
        wr_l = ~s_r.bus_s2[12];
        a = s_r.bus_s2[11:8];
        c = a[3];
        // bus drive only inside a selected read
        s_nxt.doe = cs_l & rd_l;
        s_nxt.rd_q = cs_l & rd_l;
        rd_go = cs_l & rd_l & ~s_r.rd_q;
        s_nxt.wv = cs_l & wr_l;
        if (s_nxt.wv)
        begin
            s_nxt.wa = a;
            s_nxt.wd = s_r.bus_s2[7:0];
        end
        wr_go = s_r.wv & ~s_nxt.wv;
        wc = s_r.wa[3];
        d = s_r.wd;

        // register read, latched at read start
        if (rd_go && !a[2])
        begin
            case (a[1:0])
                2'h0:
                begin
                    s_nxt.dout = (s_r.mrp[c] == MRP_0) ? s_r.mr0[c] :
                                 (s_r.mrp[c] == MRP_1) ? s_r.mr1[c] :
                                 s_r.mr2[c];
                    s_nxt.mrp[c] = (s_r.mrp[c] == MRP_0) ? MRP_1 : MRP_2;
                end
                2'h1:    s_nxt.dout = s_r.sr[c];
                2'h3:
                begin
                    s_nxt.dout = mem_q[{c, 1'b0}];
                    rx_pop_go[c] = (s_r.rx_cnt[c] != 4'h0);
                end
                default: s_nxt.dout = 8'h00;
            endcase
        end
        else if (rd_go)
        begin
            case (a)
                A_IPCR:
                begin
                    s_nxt.dout = {s_r.cos, s_r.ip_s2[3:0]};
                    s_nxt.cos = 4'h0;
                end
                A_ISR:   s_nxt.dout = s_r.irq_status_reg;
                A_OUT_PORT_CONFIG_REG:  s_nxt.dout = {1'b0, s_r.ip_s2};
                default: s_nxt.dout = 8'h00;
            endcase
        end

        // register write at end of write window
        if (wr_go && !s_r.wa[2])
        begin
            case (s_r.wa[1:0])
                2'h0:
                begin
                    case (s_r.mrp[wc])
                        MRP_0:   s_nxt.mr0[wc] = d;
                        MRP_1:   s_nxt.mr1[wc] = d;
                        default: s_nxt.mr2[wc] = d;
                    endcase
                    s_nxt.mrp[wc] = (s_r.mrp[wc] == MRP_0) ? MRP_1 : MRP_2;
                end
                2'h2:
                begin
                    if (d[CR_RX_EN])  s_nxt.rx_en[wc] = 1'b1;
                    if (d[CR_RX_DIS]) s_nxt.rx_en[wc] = 1'b0;
                    if (d[CR_TX_EN])  s_nxt.tx_en[wc] = 1'b1;
                    if (d[CR_TX_DIS]) s_nxt.tx_en[wc] = 1'b0;
                    case (d[6:4])
                        CMD_PTR_MR1: s_nxt.mrp[wc] = MRP_1;
                        CMD_PTR_MR0: s_nxt.mrp[wc] = MRP_0;
                        CMD_RST_RX:  rx_flush[wc] = 1'b1;
                        CMD_RST_TX:  tx_flush[wc] = 1'b1;
                        CMD_RST_ERR: s_nxt.ovr[wc] = 1'b0;
                        default:     s_nxt.ovr[wc] = s_r.ovr[wc];
                    endcase
                end
                2'h3:    tx_push_go[wc] = (s_r.tx_cnt[wc] < FIFO_DEPTH);
                default: s_nxt.dout = s_nxt.dout;
            endcase
        end
        else if (wr_go)
        begin
            case (s_r.wa)
                A_ISR:      s_nxt.irq_mask_reg = d;
                A_CT_START: s_nxt.ct_run = 1'b1;
                A_CT_STOP:
                begin
                    s_nxt.ct_run = 1'b0;
                    s_nxt.ct_flag = 1'b0;
                end
                A_OUT_PORT_CONFIG_REG:     s_nxt.out_port_config_reg = d;
                A_OP_SET:   s_nxt.out_port_reg = s_r.out_port_reg | d;
                A_OP_CLR:   s_nxt.out_port_reg = s_r.out_port_reg & ~d;
                default:    s_nxt.irq_mask_reg = s_r.irq_mask_reg;
            endcase
        end

        // buffers, status and serial lines per channel
        for (int k = 0; k < 2; k++)
        begin
            logic rpush;
            logic tpop;
            rpush = rx_push[k] & s_r.rx_en[k] &
                    (s_r.rx_cnt[k] < FIFO_DEPTH);
            tpop = tx_pop[k] & s_r.txv[k];
            if (rx_push[k] && s_r.rx_en[k] && !rpush)
                s_nxt.ovr[k] = 1'b1;
            mem_we[2*k] = rpush;
            mem_wa[2*k] = s_r.rx_wp[k];
            mem_wd[2*k] = k[0] ? rx_char_b : rx_char_a;
            mem_ra[2*k] = s_r.rx_rp[k];
            mem_we[2*k+1] = tx_push_go[k];
            mem_wa[2*k+1] = s_r.tx_wp[k];
            mem_wd[2*k+1] = d;
            mem_ra[2*k+1] = s_r.tx_rp[k];
            s_nxt.rx_wp[k] = s_r.rx_wp[k] + {2'h0, rpush};
            s_nxt.rx_rp[k] = s_r.rx_rp[k] + {2'h0, rx_pop_go[k]};
            s_nxt.rx_cnt[k] = s_r.rx_cnt[k] + {3'h0, rpush}
                              - {3'h0, rx_pop_go[k]};
            s_nxt.tx_wp[k] = s_r.tx_wp[k] + {2'h0, tx_push_go[k]};
            s_nxt.tx_rp[k] = s_r.tx_rp[k] + {2'h0, tpop};
            s_nxt.tx_cnt[k] = s_r.tx_cnt[k] + {3'h0, tx_push_go[k]}
                              - {3'h0, tpop};
            if (rx_flush[k])
            begin
                s_nxt.rx_wp[k] = 3'h0;
                s_nxt.rx_rp[k] = 3'h0;
                s_nxt.rx_cnt[k] = 4'h0;
                s_nxt.rx_en[k] = 1'b0;
            end
            if (tx_flush[k])
            begin
                s_nxt.tx_wp[k] = 3'h0;
                s_nxt.tx_rp[k] = 3'h0;
                s_nxt.tx_cnt[k] = 4'h0;
                s_nxt.tx_en[k] = 1'b0;
            end
            s_nxt.popd[k] = tpop;
            s_nxt.txv[k] = (s_r.tx_cnt[k] != 4'h0) & ~tpop & ~s_r.popd[k]
                           & ~tx_flush[k];
            s_nxt.sr[k] = {3'h0, s_r.ovr[k], s_r.tx_cnt[k] == 4'h0,
                   lvl_hit(s_r.tx_cnt[k], s_r.mr0[k][MR0_TXLVL +: 2], 1'b1)
                   & s_r.tx_en[k],
                   s_r.rx_cnt[k] == 4'h8, s_r.rx_cnt[k] != 4'h0};
            s_nxt.irq_status_reg[4*k] = s_r.sr[k][SR_TXRDY];
            s_nxt.irq_status_reg[4*k+1] =
                lvl_hit(s_r.rx_cnt[k], s_r.mr0[k][MR0_RXLVL +: 2], 1'b0)
                & (s_r.rx_cnt[k] != 4'h0);
            s_nxt.irq_status_reg[4*k+2] = s_r.sr[k][SR_OVR];
            // mark while disabled or looped back
            s_nxt.ser[k] = (s_r.tx_en[k] &&
                s_r.mr2[k][MR2_MODE +: 2] != MODE_LOOP) ?
                tx_line[k] : 1'b1;
        end

        // change of state on four inputs; a change beats a read clear
        for (int k = 0; k < COS_W; k++)
        begin
            if (s_r.ip_s2[k] != s_r.ip_s3[k])
                s_nxt.cos[k] = 1'b1;
        end
        if (s_r.ct_run && ct_expire)
            s_nxt.ct_flag = 1'b1;
        s_nxt.irq_status_reg[ISR_CT] = s_r.ct_flag;
        s_nxt.irq_status_reg[ISR_COS] = |s_r.cos;
        s_nxt.irq_oe = |(s_r.irq_status_reg & s_r.irq_mask_reg);

        // port pins: plain output or open-drain request
        for (int k = 0; k < 8; k++)
        begin
            if (k >= 2 && s_r.out_port_config_reg[k])
            begin
                s_nxt.gp_out[k] = 1'b0;
                s_nxt.gp_oe[k] = s_r.irq_status_reg[op_src(k)];
            end
            else
            begin
                s_nxt.gp_out[k] = ~s_r.out_port_reg[k];
                s_nxt.gp_oe[k] = 1'b1;
            end
        end

        // synchronous reset
        if (!rst_n)
        begin
            // synchronisers keep shifting: no false strobe or change
            s_nxt = '{bus_s1: s_nxt.bus_s1, bus_s2: s_nxt.bus_s2,
                      ip_s1: s_nxt.ip_s1, ip_s2: s_nxt.ip_s2,
                      ip_s3: s_nxt.ip_s3, default: '0};
            s_nxt.gp_out = RST_GP_OUT;
            s_nxt.gp_oe = RST_GP_OE;
            s_nxt.ser = RST_SER;
            s_nxt.mrp = {MRP_1, MRP_1};
        end
    end

    // state register
    always_ff @(posedge clk)
    begin
        s_r <= s_nxt;
    end

    // outputs
    assign host_data_out      = s_r.dout;
    assign host_data_oe       = s_r.doe;
    assign irq_request_n      = 1'b0;
    assign irq_request_n_oe   = s_r.irq_oe;
    assign general_outputs    = s_r.gp_out;
    assign general_outputs_oe = s_r.gp_oe;
    assign serial_out_a       = s_r.ser[0];
    assign serial_out_b       = s_r.ser[1];
    assign tx_valid           = s_r.txv;
    assign tx_char_a          = mem_q[1];
    assign tx_char_b          = mem_q[3];
    assign rx_enabled         = s_r.rx_en;
    assign tx_enabled         = s_r.tx_en;
    assign ct_running         = s_r.ct_run;

    ////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence seq_sel_read;
        rd_go && !s_r.bus_s2[11] && s_r.bus_s2[10:8] == 3'h1;
    endsequence

    chk_bus_float: assert property (!cs_l |=> !host_data_oe)
        else $error("bus driven while deselected");
    chk_write_set: assert property (wr_go && s_r.wa == A_OP_SET |=>
        s_r.out_port_reg == ($past(s_r.out_port_reg) | $past(s_r.wd)))
        else $error("set write lost");
    chk_read_drive: assert property (rd_go |=> host_data_oe)
        else $error("read not driven");
    chk_status_read: assert property (seq_sel_read |=>
        host_data_out == $past(s_r.sr[0]))
        else $error("status read wrong");
    chk_reset_pins: assert property (disable iff (1'b0) !rst_n |=>
        general_outputs == 8'hFF && general_outputs_oe == 8'hFF
        && !ct_running)
        else $error("reset pins wrong");
    chk_reset_line: assert property (disable iff (1'b0) !rst_n |=>
        serial_out_a && serial_out_b && tx_enabled == 2'h0)
        else $error("reset line wrong");
    chk_reset_mode: assert property (disable iff (1'b0) !rst_n |=>
        s_r.mrp == {MRP_1, MRP_1} && s_r.mr0 == '0 && s_r.irq_mask_reg == 8'h00
        && s_r.out_port_config_reg == 8'h00 && s_r.irq_status_reg == 8'h00)
        else $error("reset mode wrong");
    chk_irq_level: assert property ((s_r.irq_status_reg & s_r.irq_mask_reg) != 8'h00 |=>
        irq_request_n_oe)
        else $error("request missing");
    chk_fifo_depth: assert property (s_r.rx_cnt[0] <= 4'h8 &&
        s_r.tx_cnt[1] <= 4'h8)
        else $error("buffer overfilled");
    chk_op_clear: assert property (wr_go && s_r.wa == A_OP_CLR |=>
        (s_r.out_port_reg & $past(s_r.wd)) == 8'h00)
        else $error("clear write lost");
    chk_cos_flag: assert property (s_r.ip_s2[0] != s_r.ip_s3[0] |=>
        s_r.cos[0] ##1 s_r.irq_status_reg[ISR_COS])
        else $error("change not flagged");
    chk_loop_mark: assert property (s_r.mr2[0][7:6] == MODE_LOOP |=>
        serial_out_a)
        else $error("loopback not marking");
endmodule : dhp_port

/* sim/dhp_cpu.sv */
// Purpose: host processor model that runs select and strobe bus cycles
// Assumes: strobes move on the falling clock edge, one cycle at a time
// Notes:   a released data line shows the inverse of its last value
module dhp_cpu
(
    input  wire logic       clk,     // bench clock
    output logic            cs_n,    // chip select
    output logic            rd_n,    // read strobe
    output logic            wr_n,    // write strobe
    output logic [3:0]      addr,    // register address
    output logic [7:0]      dout,    // cpu data drive
    input  wire logic [7:0] bus_in,  // resolved bus level
    input  wire logic       oe_in    // device drives bus
);
    timeunit 1ns;
    timeprecision 100ps;
    initial
    begin
        {cs_n, rd_n, wr_n, addr, dout} = {3'h7, 4'h0, 8'h00};
    end
    // strobes held five cycles low and five high, never both low
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(negedge clk);
        {cs_n, wr_n, addr, dout} = {2'h0, a, d};
        repeat (5) @(negedge clk);
        {cs_n, wr_n} = 2'h3;
        dout = ~d;
        repeat (5) @(negedge clk);
    endtask : wr
    // read answer taken at the first falling edge showing the drive enable
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        int n;
        @(negedge clk);
        {cs_n, rd_n, addr} = {2'h0, a};
        n = 0;
        do
        begin
            @(negedge clk);
            n++;
        end
        while (oe_in !== 1'b1 && n < 20);
        d = (n < 20) ? bus_in : 8'hxx;
        @(negedge clk);
        {cs_n, rd_n} = 2'h3;
        repeat (5) @(negedge clk);
    endtask : rd
endmodule : dhp_cpu

/* sim/duart_host_bus_port_tb.sv */
// Purpose: self-checking bench for the host bus port
// Assumes: the cpu model runs all bus cycles
// Notes:   receive and counter inputs are held idle
module duart_host_bus_port_tb;
    timeunit 1ns;
    timeprecision 100ps;
    import dhp_pkg::*;
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin n_errors++; \
    $display("ERROR %0t: got %h want %h", $time, g, e); end end
    logic clk, rst_n, cs_n, rd_n, wr_n, doe, ioe, sa, sb, ctr, irq_n;
    logic [3:0] addr;
    logic [7:0] dout, dcpu, din, gpo, gpoe, rv, tca;
    logic [6:0] pins;
    logic [1:0] txl, txv, rxe, txe;
    int n_errors = 0;
    int n_checks = 0;
    assign din = doe ? dout : dcpu;
    ////////////////////////////////////////////////////////////////////////
    // clock, partner and device
    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    dhp_cpu cpu (.clk(clk), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n),
        .addr(addr), .dout(dcpu), .bus_in(din), .oe_in(doe));
    dhp_port dut (.clk(clk), .rst_n(rst_n), .chip_select_n(cs_n),
        .read_strobe_n(rd_n), .write_strobe_n(wr_n), .reg_addr(addr),
        .host_data_in(din), .host_data_out(dout), .host_data_oe(doe),
        .irq_request_n(irq_n), .irq_request_n_oe(ioe),
        .general_outputs(gpo), .general_outputs_oe(gpoe),
        .input_pins(pins), .serial_out_a(sa),
        .serial_out_b(sb), .tx_line(txl), .rx_push(2'h0),
        .rx_char_a(8'h00), .rx_char_b(8'h00), .tx_pop(2'h0),
        .tx_valid(txv), .tx_char_a(tca), .tx_char_b(), .rx_enabled(rxe),
        .tx_enabled(txe), .ct_expire(1'b0), .ct_running(ctr));
    ////////////////////////////////////////////////////////////////////////
    // verdict and watchdog
    task automatic summarize;
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : summarize
    initial
    begin
        #20us;
        n_errors++;
        summarize();
    end
    // reset state of the output pins and the interrupt status register
    task automatic rst_check;
        rst_n = 1'b0;
        repeat (4) @(negedge clk);
        rst_n = 1'b1;
        `CHK({gpo, gpoe}, 16'hFFFF)
        `CHK({sa, sb, ctr, doe, ioe}, 5'h18)
        `CHK({txe, rxe, txv}, 6'h00)
        cpu.rd(A_ISR, rv);
        `CHK(rv, 8'h00)
        $display("test reset done");
    endtask : rst_check
    ////////////////////////////////////////////////////////////////////////
    // tests
    initial
    begin
        {rst_n, pins, txl} = {1'b0, 7'h5A, 2'h0};
        rst_check();
        cpu.rd(4'hC, rv); // unmapped address
        `CHK(rv, 8'h00)
        `CHK(doe, 1'b0)
        cpu.rd(A_OUT_PORT_CONFIG_REG, rv);
        `CHK(rv, {1'b0, pins})
        cpu.wr(A_OP_SET, 8'h81);
        `CHK(gpo, 8'h7E)
        cpu.wr(A_OP_CLR, 8'h01);
        `CHK(gpo, 8'h7F)
        cpu.wr(A_CR, 8'h04); // transmitter on
        `CHK({txe[0], sa, sb}, 3'h5)
        cpu.wr(A_ISR, 8'h01);
        `CHK({irq_n, ioe}, 2'h1)
        cpu.wr(A_OUT_PORT_CONFIG_REG, 8'h40);
        `CHK({gpoe[6], gpo[6]}, 2'h2)
        cpu.wr(A_ISR, 8'h00);
        `CHK(ioe, 1'b0)
        cpu.wr(A_DAT, 8'hC3); // one character into transmit buffer
        `CHK({txv, tca}, {2'h1, 8'hC3})
        cpu.wr(A_MR, 8'h80); // first write after reset lands in mode one
        cpu.wr(A_MR, 8'h80); // loopback into mode two
        `CHK(sa, 1'b1)
        cpu.wr(A_CR, 8'h10); // pointer back to mode one
        cpu.rd(A_MR, rv);
        `CHK(rv, 8'h80)
        pins = 7'h5B; // input zero rises
        repeat (2) @(negedge clk);
        cpu.rd(A_IPCR, rv);
        `CHK(rv, 8'h1B)
        cpu.rd(A_IPCR, rv);
        `CHK(rv, 8'h0B)
        $display("test port and interrupt done");
        rst_check();
        `CHK(gpo, 8'hFF)
        summarize();
    end
endmodule : duart_host_bus_port_tb
